// ### core/clk_cfg_pkg.sv
// shared constants and carrier types for the clock and control config bank
package clk_cfg_pkg;
   // register offsets
   localparam logic [7:0] REF_CLOCK_SELECT_ADDR   = 8'h05;
   localparam logic [7:0] CLOCK_OUT_PRE_M_ADDR    = 8'h06;
   localparam logic [7:0] CLOCK_OUT_N_VALUE_ADDR  = 8'h07;
   localparam logic [7:0] LINK_WATCHDOG_CTRL_ADDR = 8'h08;
   localparam logic [7:0] TARGET_BUS_CTRL_ADDR    = 8'h09;

   // reset values
   localparam logic [7:0] REF_CLOCK_SELECT_RST    = 8'h03;
   localparam logic [7:0] CLOCK_OUT_PRE_M_RST     = 8'h41;
   localparam logic [7:0] CLOCK_OUT_N_VALUE_RST   = 8'h28;
   localparam logic [7:0] LINK_WATCHDOG_CTRL_RST  = 8'hFE;
   localparam logic [7:0] TARGET_BUS_CTRL_RST     = 8'h1E;
   localparam logic [7:0] UNMAPPED_READ_VALUE     = 8'h00;

   // field positions
   localparam int REF_DIV_LSB       = 4;
   localparam int OSC_RANGE_BIT     = 3;
   localparam int PRESCALE_LSB      = 5;
   localparam int MULT_LSB          = 0;
   localparam int TIMEOUT_LSB       = 1;
   localparam int TIMEOUT_OFF_BIT   = 0;
   localparam int WRITE_BLOCK_BIT   = 7;
   localparam int SDA_HOLD_LSB      = 4;
   localparam int FILTER_DEPTH_LSB  = 0;

   // prescale and divider codes
   localparam logic [2:0] PRESCALE_MAX_CODE = 3'h4;
   localparam logic [2:0] REF_DIV_MAX_CODE  = 3'h3;
   localparam logic [4:0] MULT_FALLBACK     = 5'h01;

   // timing figures and derived cycle counts
   localparam int CLK_PERIOD_NS      = 5;
   localparam int CLK_FREQ_KHZ       = 200000;
   localparam int TIMEOUT_STEP_MS    = 2;
   localparam int TIMEOUT_STEP_CYC   = TIMEOUT_STEP_MS * CLK_FREQ_KHZ;
   localparam int SDA_HOLD_UNIT_NS   = 50;
   localparam int SDA_HOLD_UNIT_CYC  = SDA_HOLD_UNIT_NS / CLK_PERIOD_NS;
   localparam int FILTER_UNIT_NS     = 5;
   localparam int FILTER_UNIT_CYC    = FILTER_UNIT_NS / CLK_PERIOD_NS;
   localparam int SDA_HOLD_MAX_CODE  = 7;

   // register access request from the local target / control channel
   typedef struct packed {
      logic       valid;
      logic       write;
      logic       remote;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // registered answer, one cycle after the request
   typedef struct packed {
      logic       ack;
      logic       refused;
      logic [7:0] rdata;
   } reg_rsp_t;
endpackage : clk_cfg_pkg

// ### core/clock_ctrl_cfg.sv
// clock and control-channel configuration bank with its controlled logic
module clock_ctrl_cfg #(
   parameter int TIMEOUT_STEP_CYC = clk_cfg_pkg::TIMEOUT_STEP_CYC
) (
   input  wire logic                  clk_sys_i,
   input  wire logic                  rst_b_i,
   input  wire logic                  ce_i,
   input  wire clk_cfg_pkg::reg_req_t reg_req_i,
   output      clk_cfg_pkg::reg_rsp_t reg_rsp_o,
   input  wire logic                  ref_clock_in_i,
   output      logic                  ref_clock_int_o,
   output      logic                  osc_range_select_o,
   input  wire logic                  fast_tick_i,
   output      logic                  sensor_clock_out_o,
   input  wire logic                  txn_active_i,
   output      logic                  txn_abort_o,
   output      logic                  remote_write_block_o,
   input  wire logic                  scl_pin_i,
   input  wire logic                  sda_pin_i,
   output      logic                  scl_clean_o,
   output      logic                  sda_clean_o
);
   localparam int STEP_W = $clog2(TIMEOUT_STEP_CYC + 1);
   localparam int HOLD_LEN =
      clk_cfg_pkg::SDA_HOLD_MAX_CODE * clk_cfg_pkg::SDA_HOLD_UNIT_CYC;
   localparam logic [2:0] PRE_RST =
      clk_cfg_pkg::CLOCK_OUT_PRE_M_RST[clk_cfg_pkg::PRESCALE_LSB +: 3];

   // refuse settings that the counters cannot serve
   if (TIMEOUT_STEP_CYC < 1) begin : g_bad_step
      $error("timeout step must be at least one cycle");
   end
   if (HOLD_LEN < 2) begin : g_bad_hold
      $error("sda hold line needs at least two stages");
   end

   // clamp a three-bit code to the largest value that is served
   function automatic logic [2:0] clamp_code(input logic [2:0] code,
                                             input logic [2:0] top);
      clamp_code = (code > top) ? top : code;
   endfunction : clamp_code

   // register storage
   logic [7:0] ref_sel_q;
   logic [7:0] pre_m_q;
   logic [7:0] n_val_q;
   logic [7:0] wd_ctrl_q;
   logic [7:0] bus_ctrl_q;
   clk_cfg_pkg::reg_rsp_t rsp_q;

   // address decode
   wire hit_ref   = reg_req_i.addr == clk_cfg_pkg::REF_CLOCK_SELECT_ADDR;
   wire hit_pre_m = reg_req_i.addr == clk_cfg_pkg::CLOCK_OUT_PRE_M_ADDR;
   wire hit_n     = reg_req_i.addr == clk_cfg_pkg::CLOCK_OUT_N_VALUE_ADDR;
   wire hit_wd    = reg_req_i.addr == clk_cfg_pkg::LINK_WATCHDOG_CTRL_ADDR;
   wire hit_bus   = reg_req_i.addr == clk_cfg_pkg::TARGET_BUS_CTRL_ADDR;

   // only own-register writes from the far side are gated
   wire blocked = reg_req_i.remote
                  & bus_ctrl_q[clk_cfg_pkg::WRITE_BLOCK_BIT];
   wire wr_ok   = ce_i & reg_req_i.valid & reg_req_i.write & ~blocked;

   // read selection
   logic [7:0] rd_mux;
   always_comb begin
      if (hit_ref) begin
         rd_mux = ref_sel_q;
      end else if (hit_pre_m) begin
         rd_mux = pre_m_q;
      end else if (hit_n) begin
         rd_mux = n_val_q;
      end else if (hit_wd) begin
         rd_mux = wd_ctrl_q;
      end else if (hit_bus) begin
         rd_mux = bus_ctrl_q;
      end else begin
         rd_mux = clk_cfg_pkg::UNMAPPED_READ_VALUE;
      end
   end

   // register writes and the answer
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         ref_sel_q  <= clk_cfg_pkg::REF_CLOCK_SELECT_RST;
         pre_m_q    <= clk_cfg_pkg::CLOCK_OUT_PRE_M_RST;
         n_val_q    <= clk_cfg_pkg::CLOCK_OUT_N_VALUE_RST;
         wd_ctrl_q  <= clk_cfg_pkg::LINK_WATCHDOG_CTRL_RST;
         bus_ctrl_q <= clk_cfg_pkg::TARGET_BUS_CTRL_RST;
         rsp_q      <= '0;
      end else if (ce_i) begin
         if (wr_ok && hit_ref) ref_sel_q <= reg_req_i.wdata;
         if (wr_ok && hit_pre_m) pre_m_q <= reg_req_i.wdata;
         if (wr_ok && hit_n) n_val_q <= reg_req_i.wdata;
         if (wr_ok && hit_wd) wd_ctrl_q <= reg_req_i.wdata;
         if (wr_ok && hit_bus) bus_ctrl_q <= reg_req_i.wdata;
         rsp_q.ack     <= reg_req_i.valid;
         rsp_q.refused <= reg_req_i.valid & reg_req_i.write & blocked;
         rsp_q.rdata   <= reg_req_i.write ? 8'h00 : rd_mux;
      end
   end
   // answer and field levels straight from the flops
   assign reg_rsp_o            = rsp_q;
   assign remote_write_block_o = bus_ctrl_q[clk_cfg_pkg::WRITE_BLOCK_BIT];
   assign osc_range_select_o   = ref_sel_q[clk_cfg_pkg::OSC_RANGE_BIT];

   // field views
   wire [2:0] ref_div  = ref_sel_q[clk_cfg_pkg::REF_DIV_LSB +: 3];
   wire [2:0] pre_code = pre_m_q[clk_cfg_pkg::PRESCALE_LSB +: 3];
   wire [4:0] mult_raw = pre_m_q[clk_cfg_pkg::MULT_LSB +: 5];
   wire [6:0] tmo_val  = wd_ctrl_q[clk_cfg_pkg::TIMEOUT_LSB +: 7];
   wire       tmo_off  = wd_ctrl_q[clk_cfg_pkg::TIMEOUT_OFF_BIT];
   wire [2:0] sda_hold = bus_ctrl_q[clk_cfg_pkg::SDA_HOLD_LSB +: 3];
   wire [3:0] flt_dep  = bus_ctrl_q[clk_cfg_pkg::FILTER_DEPTH_LSB +: 4];

   // reference input: synchronise, count rising edges, pick a tap
   logic       ref_s1_q;
   logic       ref_s2_q;
   logic       ref_s3_q;
   logic [2:0] ref_cnt_q;
   logic       ref_int_q;
   wire  [2:0] ref_code = clamp_code(ref_div,
                                     clk_cfg_pkg::REF_DIV_MAX_CODE);
   // tap 0 is the synchronised pin, taps 1..3 the counter bits
   wire  [3:0] ref_taps = {ref_cnt_q, ref_s2_q};
   wire        ref_rise = ref_s2_q & ~ref_s3_q;
   wire        ref_sel  = ref_taps[ref_code[1:0]];
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         ref_s1_q  <= 1'b0;
         ref_s2_q  <= 1'b0;
         ref_s3_q  <= 1'b0;
         ref_cnt_q <= 3'h0;
         ref_int_q <= 1'b0;
      end else if (ce_i) begin
         ref_s1_q  <= ref_clock_in_i;
         ref_s2_q  <= ref_s1_q;
         ref_s3_q  <= ref_s2_q;
         if (ref_rise) ref_cnt_q <= 3'(ref_cnt_q + 3'h1);
         ref_int_q <= ref_sel;
      end
   end
   assign ref_clock_int_o = ref_int_q;

   // fast clock prescaler, reserved codes clamp to divide by 16;
   // the code in use is taken over at a sensor clock period start
   logic [3:0] pre_cnt_q;
   logic [2:0] pre_act_q;
   wire  [2:0] pre_eff  = clamp_code(pre_code,
                                     clk_cfg_pkg::PRESCALE_MAX_CODE);
   wire  [4:0] pre_div  = 5'h01 << pre_act_q;
   wire        pre_tick = fast_tick_i
                          & ({1'b0, pre_cnt_q} == 5'(pre_div - 5'h01));
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         pre_cnt_q <= 4'h0;
      end else if (ce_i && fast_tick_i) begin
         pre_cnt_q <= pre_tick ? 4'h0 : 4'(pre_cnt_q + 4'h1);
      end
   end

   // ratio divider: accumulator adds 2M per tick, toggles on wrap at or past N
   logic [4:0] m_act_q;
   logic [7:0] n_act_q;
   logic [8:0] acc_q;
   logic       sclk_q;
   wire  [4:0] mult_eff = (mult_raw == 5'h00)
                          ? clk_cfg_pkg::MULT_FALLBACK : mult_raw;
   wire  [8:0] acc_sum  = 9'(acc_q + {3'h0, m_act_q, 1'b0});
   wire        wrap     = pre_tick & (n_act_q != 8'h00)
                          & (acc_sum >= {1'b0, n_act_q});
   wire        new_per  = wrap & ~sclk_q;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         pre_act_q <= PRE_RST;
         m_act_q <= clk_cfg_pkg::MULT_FALLBACK;
         n_act_q <= clk_cfg_pkg::CLOCK_OUT_N_VALUE_RST;
         acc_q   <= 9'h000;
         sclk_q  <= 1'b0;
      end else if (ce_i) begin
         if (new_per) begin
            // settings change only as a fresh period starts
            pre_act_q <= pre_eff;
            m_act_q <= mult_eff;
            if (n_val_q != 8'h00) n_act_q <= n_val_q;
            acc_q   <= 9'h000;
         end else if (wrap) begin
            acc_q   <= 9'(acc_sum - {1'b0, n_act_q});
         end else if (pre_tick) begin
            acc_q   <= acc_sum;
         end
         if (wrap) sclk_q <= ~sclk_q;
      end
   end
   // sensor clock leaves from its flop
   assign sensor_clock_out_o = sclk_q;

   // control-channel watchdog
   logic [STEP_W-1:0] step_q;
   logic [6:0]        unit_q;
   logic              fired_q;
   logic              abort_q;
   wire  step_done = step_q == STEP_W'(TIMEOUT_STEP_CYC - 1);
   wire  wd_run    = txn_active_i & ~tmo_off;
   wire  expire    = wd_run & ~fired_q & (unit_q >= tmo_val);
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         step_q  <= '0;
         unit_q  <= 7'h00;
         fired_q <= 1'b0;
         abort_q <= 1'b0;
      end else if (ce_i) begin
         abort_q <= expire;
         if (!wd_run) begin
            step_q  <= '0;
            unit_q  <= 7'h00;
            fired_q <= 1'b0;
         end else begin
            if (expire) fired_q <= 1'b1;
            step_q <= step_done ? '0 : STEP_W'(step_q + 1'b1);
            if (step_done && unit_q != 7'h7F) begin
               unit_q <= 7'(unit_q + 7'h01);
            end
         end
      end
   end
   // one-cycle terminate pulse
   assign txn_abort_o = abort_q;

   // glitch filters on scl (0) and sda (1)
   wire  [1:0] pin_in = {sda_pin_i, scl_pin_i};
   logic [1:0] flt_out;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_flt
         logic       s1_q;
         logic       s2_q;
         logic       lvl_q;
         logic [3:0] cnt_q;
         wire        accept = cnt_q >= 4'(flt_dep
                              * clk_cfg_pkg::FILTER_UNIT_CYC);
         always_ff @(posedge clk_sys_i) begin
            if (!rst_b_i) begin
               s1_q  <= 1'b1;
               s2_q  <= 1'b1;
               lvl_q <= 1'b1;
               cnt_q <= 4'h0;
            end else if (ce_i) begin
               s1_q <= pin_in[g];
               s2_q <= s1_q;
               if (s2_q == lvl_q) begin
                  cnt_q <= 4'h0;
               end else if (accept) begin
                  lvl_q <= s2_q;
                  cnt_q <= 4'h0;
               end else begin
                  cnt_q <= 4'(cnt_q + 4'h1);
               end
            end
         end
         assign flt_out[g] = lvl_q;
      end
   endgenerate

   // sda hold delay line, tap chosen by the hold field
   logic [HOLD_LEN-1:0] hold_line_q;
   logic                scl_out_q;
   logic                sda_out_q;
   wire  [6:0] hold_cyc = 7'(sda_hold * clk_cfg_pkg::SDA_HOLD_UNIT_CYC);
   wire        sda_held = (hold_cyc == 7'h00) ? flt_out[1]
                          : hold_line_q[7'(hold_cyc - 7'h01)];
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         hold_line_q <= '1;
         scl_out_q   <= 1'b1;
         sda_out_q   <= 1'b1;
      end else if (ce_i) begin
         hold_line_q <= {hold_line_q[HOLD_LEN-2:0], flt_out[1]};
         scl_out_q   <= flt_out[0];
         sda_out_q   <= sda_held;
      end
   end
   // cleaned levels from their output flops
   assign scl_clean_o = scl_out_q;
   assign sda_clean_o = sda_out_q;
endmodule : clock_ctrl_cfg

// ### testbench/cfg_master_model.sv
// register master standing in for local or far-side software
module cfg_master_model (
   input  wire logic                  clk_sys_i,
   output      clk_cfg_pkg::reg_req_t reg_req_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial reg_req_o = '0;
   // one byte access; released fields show inverted junk
   task automatic access(input logic w, r, input logic [7:0] a, d);
      @(negedge clk_sys_i);
      reg_req_o <= '{1'b1, w, r, a, d};
      @(negedge clk_sys_i);
      reg_req_o <= '{1'b0, ~w, ~r, ~a, ~d};
   endtask : access
endmodule : cfg_master_model

// ### testbench/clk_cfg_monitor.sv
// assertions on the register port, watchdog and write block
module clk_cfg_monitor (
   input wire logic                  clk_sys_i,
   input wire logic                  rst_b_i,
   input wire logic                  ce_i,
   input wire clk_cfg_pkg::reg_req_t reg_req_i,
   input wire clk_cfg_pkg::reg_rsp_t reg_rsp_o,
   input wire logic                  osc_range_select_o,
   input wire logic                  txn_active_i,
   input wire logic                  txn_abort_o,
   input wire logic                  remote_write_block_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   // accepted request, and a write that is not blocked
   wire take  = ce_i && reg_req_i.valid;
   wire wr_ok = take && reg_req_i.write
                && !(reg_req_i.remote && remote_write_block_o);

   ack_follows_a: assert property (
      take |=> reg_rsp_o.ack) else $error("request without ack");
   ack_cause_a: assert property (
      reg_rsp_o.ack |-> $past(take)) else $error("ack without request");
   remote_refuse_a: assert property (
      take && reg_req_i.write && reg_req_i.remote && remote_write_block_o
      |=> reg_rsp_o.refused) else $error("blocked write not refused");
   local_accept_a: assert property (
      take && !reg_req_i.remote |=> !reg_rsp_o.refused)
      else $error("local access refused");
   osc_update_a: assert property (
      wr_ok && reg_req_i.addr == 8'h05
      |=> osc_range_select_o == $past(reg_req_i.wdata[3]))
      else $error("osc range not updated");
   block_update_a: assert property (
      wr_ok && reg_req_i.addr == 8'h09
      |=> remote_write_block_o == $past(reg_req_i.wdata[7]))
      else $error("write block not updated");
   abort_single_a: assert property (
      txn_abort_o |=> !txn_abort_o) else $error("abort longer than one");
   abort_active_a: assert property (
      txn_abort_o |-> $past(txn_active_i)) else $error("abort when idle");
   abort_early_a: assert property (
      $rose(txn_active_i) |=> !txn_abort_o ##1 !txn_abort_o)
      else $error("abort too early");
endmodule : clk_cfg_monitor

bind clock_ctrl_cfg clk_cfg_monitor mon_u (.clk_sys_i, .rst_b_i, .ce_i,
   .reg_req_i, .reg_rsp_o, .osc_range_select_o, .txn_active_i,
   .txn_abort_o, .remote_write_block_o);

// ### testbench/clock_and_ctrl_channel_cfg_tb_top.sv
// self-checking bench for the clock and control config bank
module clock_and_ctrl_channel_cfg_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic rf; logic [7:0] rd;} exp_t;
   clk_cfg_pkg::reg_req_t reg_req_i;
   clk_cfg_pkg::reg_rsp_t reg_rsp_o;
   logic clk_sys_i = 1'b0, rst_b_i = 1'b0, ref_clock_in_i = 1'b0;
   logic fast_tick_i = 1'b0, tick_all = 1'b0, txn_active_i = 1'b0;
   logic scl_pin_i = 1'b1, sda_pin_i = 1'b1;
   logic ref_clock_int_o, osc_range_select_o, sensor_clock_out_o;
   logic txn_abort_o, remote_write_block_o, scl_clean_o, sda_clean_o;
   exp_t exp_q[$];
   int   n_errors  = 0;
   int   cmp_count = 0;

   // clocks; reference pin changes on falling edges
   always #2.5 clk_sys_i = ~clk_sys_i;
   always #10 ref_clock_in_i = ~ref_clock_in_i;
   always @(negedge clk_sys_i) fast_tick_i <= tick_all | 1'($urandom);

   clock_ctrl_cfg #(.TIMEOUT_STEP_CYC(4)) dut_u (
      .clk_sys_i, .rst_b_i, .ce_i(1'b1), .reg_req_i, .reg_rsp_o,
      .ref_clock_in_i, .ref_clock_int_o, .osc_range_select_o,
      .fast_tick_i, .sensor_clock_out_o, .txn_active_i, .txn_abort_o,
      .remote_write_block_o, .scl_pin_i, .sda_pin_i, .scl_clean_o,
      .sda_clean_o);
   cfg_master_model mst_u (.clk_sys_i, .reg_req_o(reg_req_i));

   task automatic give_verdict;
      if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s: expected %0h seen %0h", nm, e, s);
      end
   endtask : chk

   // note the answer, then let the master issue the access
   task automatic acc(logic w, r, logic [7:0] a, d, logic rf, logic [7:0] rd);
      exp_q.push_back('{rf, w ? 8'h00 : rd});
      mst_u.access(w, r, a, d);
   endtask : acc

   // falling edges until a level is seen, bounded
   task automatic wait_for(const ref logic s, input logic v, output int n);
      n = 0;
      while (s !== v && n < 5000) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n >= 5000) begin
         chk("wait bound", 16'h0, 16'h1);
         give_verdict();
      end
   endtask : wait_for

   // answers taken off the queue as they appear
   always @(negedge clk_sys_i) begin : watch
      exp_t e;
      if (reg_rsp_o.ack === 1'b1) begin
         if (exp_q.size() == 0) chk("spurious ack", 16'h0, 16'h1);
         else begin
            e = exp_q.pop_front();
            chk("refused", 16'(e.rf), 16'(reg_rsp_o.refused));
            chk("rdata", 16'(e.rd), 16'(reg_rsp_o.rdata));
         end
      end
   end

   initial begin : main
      logic [7:0] v, sv[5];
      logic [7:0] rv[6] = '{8'h03, 8'h41, 8'h28, 8'hFE, 8'h1E, 8'h00};
      int cs[5][4] = '{'{2, 1, 40, 80}, '{0, 0, 8, 4}, '{4, 1, 2, 16},
                       '{1, 3, 12, 4}, '{3, 2, 8, 16}};
      int n, m;
      void'($urandom(32'hD980));
      repeat (20) @(negedge clk_sys_i);
      rst_b_i = 1'b1;
      // reset values, unmapped place included
      for (int i = 0; i < 6; i++) acc(0, 0, 8'h05 + 8'(i), 0, 0, rv[i]);
      acc(1, 0, 8'h0A, 8'h5A, 0, 0);
      acc(0, 0, 8'h0A, 0, 0, 8'h00);
      // random write then read back
      for (int i = 0; i < 5; i++) begin
         v = 8'($urandom);
         if (i == 1 || i == 2) v[0] = 1'b1;
         if (i == 3) v[1] = 1'b1;
         if (i == 4) v[7] = 1'b0;
         sv[i] = v;
         acc(1, 0, 8'h05 + 8'(i), v, 0, 0);
         acc(0, 0, 8'h05 + 8'(i), 0, 0, v);
      end
      // remote writes refused only while blocked
      acc(1, 0, 8'h09, 8'h9E, 0, 0);
      acc(1, 1, 8'h07, 8'h33, 1, 0);
      acc(0, 1, 8'h07, 0, 0, sv[2]);
      acc(1, 0, 8'h09, 8'h1E, 0, 0);
      acc(1, 1, 8'h07, 8'h33, 0, 0);
      acc(0, 1, 8'h07, 0, 0, 8'h33);
      // watchdog: two steps, then disabled
      acc(1, 0, 8'h08, 8'h04, 0, 0);
      txn_active_i = 1'b1;
      wait_for(txn_abort_o, 1'b1, n);
      chk("abort delay", 16'd9, 16'(n));
      txn_active_i = 1'b0;
      acc(1, 0, 8'h08, 8'h05, 0, 0);
      txn_active_i = 1'b1;
      m = 0;
      for (int i = 0; i < 30; i++) begin
         @(negedge clk_sys_i);
         if (txn_abort_o !== 1'b0) m++;
      end
      chk("abort while off", 16'h0, 16'(m));
      txn_active_i = 1'b0;
      // sensor clock high phase per prescale, multiplier, divisor
      tick_all = 1'b1;
      foreach (cs[i]) begin
         acc(1, 0, 8'h06, {3'(cs[i][0]), 5'(cs[i][1])}, 0, 0);
         acc(1, 0, 8'h07, 8'(cs[i][2]), 0, 0);
         repeat (2) wait_for(sensor_clock_out_o, 1'b0, n);
         repeat (2) wait_for(sensor_clock_out_o, 1'b1, n);
         wait_for(sensor_clock_out_o, 1'b0, n);
         chk("sensor half period", 16'(cs[i][3]), 16'(n));
      end
      tick_all = 1'b0;
      // reference divider codes
      for (int c = 0; c < 4; c++) begin
         acc(1, 0, 8'h05, 8'(c << 4) | 8'h0B, 0, 0);
         chk("osc range", 16'h1, 16'(osc_range_select_o));
         repeat (2) wait_for(ref_clock_int_o, 1'b1, n);
         wait_for(ref_clock_int_o, 1'b0, n);
         wait_for(ref_clock_int_o, 1'b1, n);
         wait_for(ref_clock_int_o, 1'b0, m);
         chk("ref period", 16'(4 << c), 16'(n + m));
      end
      // 14 cycle glitch rejected, then sda lags scl by the hold
      scl_pin_i = 1'b0;
      sda_pin_i = 1'b0;
      repeat (14) @(negedge clk_sys_i);
      scl_pin_i = 1'b1;
      sda_pin_i = 1'b1;
      m = 0;
      for (int i = 0; i < 40; i++) begin
         @(negedge clk_sys_i);
         if ({scl_clean_o, sda_clean_o} !== 2'b11) m++;
      end
      chk("glitch passed", 16'h0, 16'(m));
      scl_pin_i = 1'b0;
      sda_pin_i = 1'b0;
      wait_for(scl_clean_o, 1'b0, n);
      wait_for(sda_clean_o, 1'b0, m);
      chk("sda hold gap", 16'd10, 16'(m));
      repeat (4) @(negedge clk_sys_i);
      chk("queue left", 16'h0, 16'(exp_q.size()));
      give_verdict();
   end
endmodule : clock_and_ctrl_channel_cfg_tb_top
